// ---- include/wdt_regs.vh ----
// register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

`define WD_ADDR_RESET_CAUSE 1'h0
`define WD_ADDR_CONTROL 1'h1

`define WD_CAUSE_WD_BIT 3
`define WD_CAUSE_BROWNOUT_BIT 2
`define WD_CAUSE_PIN_BIT 1
`define WD_CAUSE_POWERON_BIT 0

`define WD_CTL_IRQ_FLAG_BIT 7
`define WD_CTL_IRQ_ENABLE_BIT 6
`define WD_CTL_PERIOD_TOP_BIT 5
`define WD_CTL_UNLOCK_BIT 4
`define WD_CTL_RESET_ENABLE_BIT 3

`define WD_PERIOD_RESET 4'h0
`define WD_PERIOD_MAX_VALID 4'h9
`define WD_OSC_FREQ_KHZ 128
`define WD_BASE_OSC_CYCLES 2048
`define WD_UNLOCK_WINDOW_CYCLES 3'h4

`endif

// ---- logic/watchdog_with_reset_cause_flags.v ----
// watchdog timer with reset-cause status flags
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.vh"
// Overview of operation
// - counter advances on 128 kHz watchdog oscillator
// - counter cleared by restart, disable, chip reset
// - period code n gives 2048 shl n cycles
// - reserved period codes fall back to valid period
// - enable bits select stopped, irq, reset, combined
// - always-on fuse forces reset mode, enable reads one
// - starts disabled; enabling and period change free
// - clearing reset enable needs unlock write then write within four
// - fuse level: period change needs unlock sequence
// - unlock bit self-clears four cycles after set
// - timeout in irq or combined mode sets irq flag; vector or one clears
// - irq request needs flag, enable, global enable
// - vector in combined mode clears enable and flag
// - combined mode: unserviced flag at next timeout resets system
// - timeout in reset mode resets the chip
// - reset enable forced while watchdog cause flag set
// - watchdog cause flag: set by wd reset
// - brown-out cause flag: set by brown-out reset
// - pin cause flag: set by pin reset
// - power-on flag set by power-on, software clears
// - reset-cause bits 7 to 4 read zero
// - control register bit layout
// - watchdog reset pulse lasts one clock cycle
module watchdog_with_reset_cause_flags #(
    parameter BASE_OSC_CYCLES = `WD_BASE_OSC_CYCLES
) (
    input wire clk,
    input wire reset_n,
    input wire reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire wd_osc,
    input wire wd_restart_instruction,
    input wire wd_irq_ack,
    input wire global_irq_enable,
    input wire wd_always_on_fuse,
    input wire brownout_reset_event,
    input wire pin_reset_event,
    output reg wd_irq_request,
    output reg wd_system_reset
);

    // ********************************************************
    // reset release and oscillator synchroniser
    // ********************************************************
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    reg osc_meta_reg;
    reg osc_sync_reg;
    reg osc_prev_reg;
    reg fuse_meta_reg;
    reg fuse_reg;
    wire osc_tick;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            fuse_meta_reg <= 1'b0;
            fuse_reg <= 1'b0;
        end
        else
        begin
            osc_meta_reg <= wd_osc;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
            fuse_meta_reg <= wd_always_on_fuse;
            fuse_reg <= fuse_meta_reg;
        end
    end

    // rising edge of the watchdog oscillator
    assign osc_tick = osc_sync_reg & ~osc_prev_reg;

    // ********************************************************
    // control state
    // ********************************************************
    reg irq_flag_reg;
    reg irq_enable_reg;
    reg unlock_reg;
    reg reset_enable_reg;
    reg [3:0] period_reg;
    reg [2:0] unlock_cnt_reg;
    reg [20:0] count_reg;
    reg wd_cause_reg;
    reg brownout_cause_reg;
    reg pin_cause_reg;
    reg poweron_cause_reg;

    wire reset_enable_eff;
    wire enabled;
    wire [3:0] period_eff;
    wire [20:0] limit;
    wire timeout;
    wire combined;
    wire fire_reset;
    wire chip_reset;
    wire wr_cause;
    wire wr_ctl;
    wire unlock_req;
    wire unlock_open;

    assign reset_enable_eff = reset_enable_reg | wd_cause_reg | fuse_reg;
    assign enabled = fuse_reg | reset_enable_eff | irq_enable_reg;
    assign period_eff = (period_reg > `WD_PERIOD_MAX_VALID) ?
        `WD_PERIOD_MAX_VALID : period_reg;
    assign limit = BASE_OSC_CYCLES[20:0] << period_eff;
    assign timeout = enabled & osc_tick & (count_reg == limit - 21'h1);
    assign combined = ~fuse_reg & reset_enable_eff & irq_enable_reg;

    // reset on timeout: pure reset mode, or combined with flag pending
    assign fire_reset = timeout & (fuse_reg | (reset_enable_eff & ~irq_enable_reg)
        | (combined & irq_flag_reg));
    assign chip_reset = wd_system_reset | brownout_reset_event | pin_reset_event;

    assign wr_cause = reg_wr & (reg_addr == `WD_ADDR_RESET_CAUSE);
    assign wr_ctl = reg_wr & (reg_addr == `WD_ADDR_CONTROL);
    assign unlock_req = wr_ctl & reg_wdata[`WD_CTL_UNLOCK_BIT]
        & reg_wdata[`WD_CTL_RESET_ENABLE_BIT];
    assign unlock_open = unlock_reg;

    // ********************************************************
    // watchdog counter
    // ********************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 21'h00_0000;
        end
        else if (chip_reset | wd_restart_instruction | ~enabled | timeout)
        begin
            count_reg <= 21'h00_0000;
        end
        else if (osc_tick)
        begin
            count_reg <= count_reg + 21'h1;
        end
    end

    // ********************************************************
    // system reset pulse and interrupt request
    // ********************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wd_system_reset <= 1'b0;
            wd_irq_request <= 1'b0;
        end
        else
        begin
            wd_system_reset <= fire_reset & ~wd_system_reset;
            wd_irq_request <= irq_flag_reg & irq_enable_reg & global_irq_enable
                & ~wd_irq_ack & ~chip_reset;
        end
    end

    // ********************************************************
    // control register and unlock window
    // ********************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_flag_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            unlock_reg <= 1'b0;
            reset_enable_reg <= 1'b0;
            period_reg <= `WD_PERIOD_RESET;
            unlock_cnt_reg <= 3'h0;
        end
        else if (chip_reset)
        begin
            irq_flag_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            unlock_reg <= 1'b0;
            reset_enable_reg <= fuse_reg | wd_system_reset | wd_cause_reg;
            period_reg <= `WD_PERIOD_RESET;
            unlock_cnt_reg <= 3'h0;
        end
        else
        begin
            // flag: set by timeout wins over vector and write-one clear
            if (timeout & ~fire_reset & irq_enable_reg)
            begin
                irq_flag_reg <= 1'b1;
            end
            else if (wd_irq_ack | (wr_ctl & reg_wdata[`WD_CTL_IRQ_FLAG_BIT]))
            begin
                irq_flag_reg <= 1'b0;
            end

            if (wd_irq_ack & combined)
            begin
                irq_enable_reg <= 1'b0;
            end
            else if (wr_ctl)
            begin
                irq_enable_reg <= reg_wdata[`WD_CTL_IRQ_ENABLE_BIT];
            end

            if (unlock_req)
            begin
                // open window; second write must follow within four cycles
                unlock_reg <= 1'b1;
                unlock_cnt_reg <= `WD_UNLOCK_WINDOW_CYCLES;
                reset_enable_reg <= 1'b1;
                if (!fuse_reg)
                begin
                    period_reg <= {reg_wdata[`WD_CTL_PERIOD_TOP_BIT], reg_wdata[2:0]};
                end
            end
            else if (wr_ctl & unlock_open & ~reg_wdata[`WD_CTL_UNLOCK_BIT])
            begin
                unlock_reg <= 1'b0;
                unlock_cnt_reg <= 3'h0;
                period_reg <= {reg_wdata[`WD_CTL_PERIOD_TOP_BIT], reg_wdata[2:0]};
                if (!fuse_reg)
                begin
                    // clearing has no effect while the watchdog cause flag stands
                    reset_enable_reg <= reg_wdata[`WD_CTL_RESET_ENABLE_BIT]
                        | wd_cause_reg;
                end
            end
            else
            begin
                if (unlock_cnt_reg == 3'h1)
                begin
                    unlock_reg <= 1'b0;
                end
                if (unlock_cnt_reg != 3'h0)
                begin
                    unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
                end
                if (wr_ctl & ~fuse_reg)
                begin
                    // enabling is free, clearing needs the window
                    reset_enable_reg <= reset_enable_reg
                        | reg_wdata[`WD_CTL_RESET_ENABLE_BIT];
                    period_reg <= {reg_wdata[`WD_CTL_PERIOD_TOP_BIT], reg_wdata[2:0]};
                end
            end
        end
    end

    // ********************************************************
    // reset-cause flags
    // ********************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wd_cause_reg <= 1'b0;
            brownout_cause_reg <= 1'b0;
            pin_cause_reg <= 1'b0;
            poweron_cause_reg <= 1'b1;
        end
        else
        begin
            // a reset event in the same cycle as a clearing write wins
            if (wd_system_reset)
            begin
                wd_cause_reg <= 1'b1;
            end
            else if (wr_cause & ~reg_wdata[`WD_CAUSE_WD_BIT])
            begin
                wd_cause_reg <= 1'b0;
            end
            if (brownout_reset_event)
            begin
                brownout_cause_reg <= 1'b1;
            end
            else if (wr_cause & ~reg_wdata[`WD_CAUSE_BROWNOUT_BIT])
            begin
                brownout_cause_reg <= 1'b0;
            end
            if (pin_reset_event)
            begin
                pin_cause_reg <= 1'b1;
            end
            else if (wr_cause & ~reg_wdata[`WD_CAUSE_PIN_BIT])
            begin
                pin_cause_reg <= 1'b0;
            end
            if (wr_cause & ~reg_wdata[`WD_CAUSE_POWERON_BIT])
            begin
                poweron_cause_reg <= 1'b0;
            end
        end
    end

    // ********************************************************
    // register read port
    // ********************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `WD_ADDR_RESET_CAUSE)
            begin
                reg_rdata <= {4'h0, wd_cause_reg, brownout_cause_reg,
                    pin_cause_reg, poweron_cause_reg};
            end
            else
            begin
                reg_rdata <= {irq_flag_reg, irq_enable_reg, period_reg[3], unlock_reg,
                    reset_enable_eff, period_reg[2:0]};
            end
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // watchdog_with_reset_cause_flags
`default_nettype wire

// ---- tb/wdt_sva.sv ----
// assertions on the watchdog ports
`timescale 1ns/100ps
`default_nettype none
module wdt_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic wd_restart_instruction,
    input wire logic wd_irq_ack,
    input wire logic global_irq_enable,
    input wire logic wd_always_on_fuse,
    input wire logic wd_irq_request,
    input wire logic wd_system_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [2:0] since_unlock_reg;
    wire unlock_wr = reg_wr && reg_addr && reg_wdata[4] && reg_wdata[3];
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            since_unlock_reg <= 3'h7;
        else if (unlock_wr)
            since_unlock_reg <= 3'h0;
        else if (since_unlock_reg != 3'h7)
            since_unlock_reg <= since_unlock_reg + 3'h1;
    end
    a_pulse_one_cycle: assert property (wd_system_reset |=> !wd_system_reset)
        else $error("reset pulse too long");
    a_req_needs_global: assert property (wd_irq_request |-> $past(global_irq_enable))
        else $error("request without global enable");
    a_cause_upper_zero: assert property ($past(reg_rd) && !$past(reg_addr) |->
        reg_rdata[7:4] == 4'h0) else $error("cause upper bits set");
    a_fuse_reset_en: assert property ($past(reg_rd) && $past(reg_addr) &&
        $past(wd_always_on_fuse, 6) |-> reg_rdata[3]) else $error("reset enable low");
    a_unlock_window: assert property ($past(reg_rd) && $past(reg_addr) &&
        reg_rdata[4] |-> since_unlock_reg <= 3'h4) else $error("unlock bit stays");
    a_ack_drops_req: assert property (wd_irq_ack |-> ##2 !wd_irq_request)
        else $error("request after ack");
    a_restart_quiet: assert property (wd_restart_instruction |->
        ##2 !wd_system_reset [*8]) else $error("reset after restart");
    a_reset_drops_req: assert property (wd_system_reset |-> ##3 !wd_irq_request)
        else $error("request after chip reset");
    cover property (wd_system_reset);
    cover property ($rose(wd_irq_request));
    cover property (unlock_wr);
endmodule // wdt_sva
`default_nettype wire

// ---- tb/core_partner.sv ----
// core side model: watchdog oscillator, vector ack, restart
`timescale 1ns/100ps
`default_nettype none
module core_partner (
    input wire logic clk,
    input wire logic wd_irq_request,
    input wire logic ack_on,
    input wire logic kick_on,
    output logic wd_osc,
    output logic wd_irq_ack,
    output logic wd_restart_instruction
);
    logic ack_d_reg = 1'b0;
    logic [2:0] osc_sync_reg = 3'h0;
    initial
    begin
        wd_osc = 1'b0;
        wd_irq_ack = 1'b0;
        wd_restart_instruction = 1'b0;
        forever
            #3906.3 wd_osc = ~wd_osc;
    end
    always @(posedge clk)
    begin
        osc_sync_reg <= {osc_sync_reg[1:0], wd_osc};
        ack_d_reg <= wd_irq_ack;
        wd_irq_ack <= ack_on && wd_irq_request && !wd_irq_ack && !ack_d_reg;
        wd_restart_instruction <= kick_on && osc_sync_reg[1] && !osc_sync_reg[2];
    end
endmodule // core_partner
`default_nettype wire

// ---- tb/test_watchdog_with_reset_cause_flags.sv ----
// self-checking bench for the watchdog with reset-cause flags
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_watchdog_with_reset_cause_flags;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_addr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic global_irq_enable = 1'b1;
    logic wd_always_on_fuse = 1'b0;
    logic brownout_reset_event = 1'b0;
    logic pin_reset_event = 1'b0;
    logic ack_on = 1'b0;
    logic kick_on = 1'b0;
    wire [7:0] reg_rdata;
    wire wd_osc, wd_irq_ack, wd_restart_instruction, wd_irq_request, wd_system_reset;
    int error_cnt = 0;
    int compares = 0;
    int n;
    watchdog_with_reset_cause_flags #(.BASE_OSC_CYCLES(4))
        u_watchdog_with_reset_cause_flags (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wd_osc(wd_osc),
        .wd_restart_instruction(wd_restart_instruction), .wd_irq_ack(wd_irq_ack),
        .global_irq_enable(global_irq_enable), .wd_always_on_fuse(wd_always_on_fuse),
        .brownout_reset_event(brownout_reset_event), .pin_reset_event(pin_reset_event),
        .wd_irq_request(wd_irq_request), .wd_system_reset(wd_system_reset));
    core_partner u_core_partner (.clk(clk), .wd_irq_request(wd_irq_request),
        .ack_on(ack_on), .kick_on(kick_on), .wd_osc(wd_osc), .wd_irq_ack(wd_irq_ack),
        .wd_restart_instruction(wd_restart_instruction));
    initial
        forever
            #2.5 clk = ~clk;
    // ****
    // bus and wait tasks
    // ****
    task wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rdc(input logic a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task wait_for(input logic want_rst);
        n = 0;
        while ((want_rst ? wd_system_reset : wd_irq_request) !== 1'b1 && n < 13000)
        begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(n < 13000, 1'b1)
    endtask
    task disable_wd;
        wr(0, 8'h00);
        wr(1, 8'h18);
        wr(1, 8'h00);
        rdc(1, 8'h00);
    endtask
    task pulse(input logic bo);
        @(posedge clk);
        brownout_reset_event <= bo;
        pin_reset_event <= !bo;
        @(posedge clk);
        brownout_reset_event <= 1'b0;
        pin_reset_event <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task test_done;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task t_irq;
        wr(1, 8'h40);
        wait_for(0);
        rdc(1, 8'hC0);
        @(posedge clk) global_irq_enable <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK(wd_irq_request, 1'b0)
        @(posedge clk) global_irq_enable <= 1'b1;
        wr(1, 8'hC0);
        rdc(1, 8'h40);
        wait_for(0);
        `CHK(n > 6220 && n < 6262, 1'b1)
        wr(1, 8'hC1);
        rdc(1, 8'h41);
        wait_for(0);
        `CHK(n > 12470 && n < 12510, 1'b1)
        wr(1, 8'hC0);
        rdc(1, 8'h40);
        @(posedge clk) kick_on <= 1'b1;
        repeat (10000) @(posedge clk);
        #1 `CHK(wd_irq_request, 1'b0)
        @(posedge clk) kick_on <= 1'b0;
        wr(1, 8'h80);
        rdc(1, 8'h00);
        $display("irq test done");
    endtask
    task t_combined;
        wr(1, 8'h48);
        wait_for(0);
        rdc(1, 8'hC8);
        wait_for(1);
        `CHK(n < 6300, 1'b1)
        rdc(0, 8'h09);
        rdc(1, 8'h08);
        wr(1, 8'h18);
        wr(1, 8'h00);
        rdc(1, 8'h08);
        wr(0, 8'h00);
        rdc(0, 8'h00);
        wr(1, 8'h00);
        rdc(1, 8'h08);
        wr(1, 8'h18);
        rdc(1, 8'h18);
        @(posedge clk);
        rdc(1, 8'h08);
        disable_wd;
        @(posedge clk) ack_on <= 1'b1;
        wr(1, 8'h48);
        wait_for(0);
        repeat (4) @(posedge clk);
        rdc(1, 8'h08);
        wait_for(1);
        @(posedge clk) ack_on <= 1'b0;
        rdc(0, 8'h08);
        disable_wd;
        $display("combined test done");
    endtask
    task t_chip;
        wr(1, 8'h07);
        rdc(1, 8'h07);
        pulse(1);
        rdc(0, 8'h04);
        rdc(1, 8'h00);
        pulse(0);
        rdc(0, 8'h06);
        @(posedge clk) reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(0, 8'h01);
        $display("chip reset test done");
    endtask
    task t_fuse;
        @(posedge clk) wd_always_on_fuse <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(1, 8'h08);
        wr(1, 8'h03);
        rdc(1, 8'h08);
        wr(1, 8'h18);
        wr(1, 8'h03);
        rdc(1, 8'h0B);
        $display("fuse test done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(0, 8'h01);
        rdc(1, 8'h00);
        t_irq;
        t_combined;
        t_chip;
        t_fuse;
        test_done;
    end
    initial
    begin
        #400000;
        `CHK(1'b0, 1'b1)
        test_done;
    end
endmodule // test_watchdog_with_reset_cause_flags
bind watchdog_with_reset_cause_flags wdt_sva u_wdt_sva (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wd_restart_instruction(wd_restart_instruction),
    .wd_irq_ack(wd_irq_ack), .global_irq_enable(global_irq_enable),
    .wd_always_on_fuse(wd_always_on_fuse), .wd_irq_request(wd_irq_request),
    .wd_system_reset(wd_system_reset));
`default_nettype wire
